// File: src/hmw_defines.vh
// Functional notes
// - Region 0 keeps a word-aligned base pointer in bits 31:2 that marks where the region starts.
// - Region 0 base and ceilings apply only to window accesses whose offset bit 15 is zero.
// - A region 0 access through the data port targets region 0 base plus the window offset.
// - Any data port read with offset bit 15 clear compares offset bits 14:2 to the read ceiling.
// - Memory is fetched into the data port only if offset bits 14:2 are below the read ceiling.
// - Any data port write with offset bit 15 clear compares offset bits 14:2 to write ceiling 14:2.
// - A permitted region 0 write stores only the addressed bytes and leaves the others untouched.
// - No memory write occurs when offset bits 14:2 are at or above write ceiling bits 14:2.
// - Accesses with offset bit 15 set use region 1 base and ceilings instead of region 0's.
`ifndef HMW_DEFINES_VH
`define HMW_DEFINES_VH

`define HMW_ADDR_W 12
`define HMW_OFF_R0_BASE 12'h104
`define HMW_OFF_R0_RD_CEIL 12'h108
`define HMW_OFF_R0_WR_CEIL 12'h10A
`define HMW_OFF_CTRL 12'h114
`define HMW_OFF_STATUS 12'h118
`define HMW_OFF_LAST_ADDR 12'h11C
`define HMW_OFF_DATA_PORT 12'h120

`define HMW_REGION_BIT 15
`define HMW_CEIL_HI 14
`define HMW_CEIL_LO 2

`define HMW_RST_BASE 30'h00000000
`define HMW_RST_CEIL 13'h0000
`define HMW_RST_CTRL 1'h1

`define HMW_CTRL_EN_BIT 0
`define HMW_ST_RD_BLK_BIT 0
`define HMW_ST_WR_BLK_BIT 1
`define HMW_ST_BUSY_BIT 2
`define HMW_ST_REGION_BIT 3
`define HMW_ST_RD_CNT_LO 8
`define HMW_ST_WR_CNT_LO 16

`endif

// File: src/hmw_region_check.v
`timescale 1ns/1ps
`default_nettype none
`include "hmw_defines.vh"

module hmw_region_check (
   input wire [15:0] window_offset_i,
   input wire [29:0] r0_base_i,
   input wire [12:0] r0_rd_ceil_i,
   input wire [12:0] r0_wr_ceil_i,
   input wire [31:0] r1_base_i,
   input wire [15:0] r1_rd_ceil_i,
   input wire [15:0] r1_wr_ceil_i,
   output wire region1_o,
   output wire [31:0] addr_o,
   output wire rd_ok_o,
   output wire wr_ok_o
);

   function below_ceil;
      input [12:0] offs;
      input [12:0] ceil;
      begin
         below_ceil = (offs < ceil);
      end
   endfunction

   wire [12:0] word_offs;
   wire [31:0] base;
   wire [12:0] rd_ceil;
   wire [12:0] wr_ceil;

   assign word_offs = window_offset_i[`HMW_CEIL_HI:`HMW_CEIL_LO];
   assign region1_o = window_offset_i[`HMW_REGION_BIT];
   // region 0 only when bit 15 clear, region 1 otherwise
   assign base = region1_o ? {r1_base_i[31:2], 2'h0} : {r0_base_i, 2'h0};
   assign rd_ceil = region1_o ? r1_rd_ceil_i[14:2] : r0_rd_ceil_i;
   assign wr_ceil = region1_o ? r1_wr_ceil_i[14:2] : r0_wr_ceil_i;
   assign addr_o = base + {17'h00000, word_offs, 2'h0};
   assign rd_ok_o = below_ceil(word_offs, rd_ceil);
   assign wr_ok_o = below_ceil(word_offs, wr_ceil);

endmodule // hmw_region_check
`default_nettype wire

// File: src/hmw_data_port.v
`timescale 1ns/1ps
`default_nettype none

module hmw_data_port (
   input wire clk_i,
   input wire nrst_i,
   input wire load_i,
   input wire [31:0] load_data_i,
   input wire wr_i,
   input wire [3:0] be_i,
   input wire [31:0] wdata_i,
   output reg [31:0] data_o
);

   function [31:0] merge_bytes;
      input [31:0] old_w;
      input [31:0] new_w;
      input [3:0] be;
      integer i;
      begin
         merge_bytes = old_w;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge_bytes[i*8 +: 8] = new_w[i*8 +: 8];
            end
         end
      end
   endfunction

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         data_o <= 32'h00000000;
      end else if (load_i) begin
         data_o <= load_data_i;
      end else if (wr_i) begin
         data_o <= merge_bytes(data_o, wdata_i, be_i);
      end
   end

endmodule // hmw_data_port
`default_nettype wire

// File: src/hmw_window.v
`timescale 1ns/1ps
`default_nettype none
`include "hmw_defines.vh"

module hmw_window #(
   parameter CNT_W = 8
) (
   input wire clk_i,
   input wire nrst_i,
   input wire [`HMW_ADDR_W-1:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   input wire [15:0] window_offset_i,
   input wire window_rd_i,
   input wire window_wr_i,
   input wire [3:0] window_be_i,
   input wire [31:0] window_wdata_i,
   output wire [31:0] window_data_port_o,
   output reg window_done_o,
   output reg window_blocked_o,
   output reg window_busy_o,
   input wire [31:0] r1_base_i,
   input wire [15:0] r1_rd_ceil_i,
   input wire [15:0] r1_wr_ceil_i,
   output reg [31:0] mem_addr_o,
   output reg mem_rd_o,
   output reg mem_wr_o,
   output reg [3:0] mem_be_o,
   output reg [31:0] mem_wdata_o,
   input wire [31:0] mem_rdata_i
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RWAIT = 2'h1;
   localparam ST_RLOAD = 2'h2;

   // software registers
   reg [29:0] r0_base_reg;
   reg [12:0] r0_rd_ceil_reg;
   reg [12:0] r0_wr_ceil_reg;
   reg ctrl_en_reg;
   reg rd_blk_reg;
   reg wr_blk_reg;
   reg region_reg;
   reg [CNT_W-1:0] rd_cnt_reg;
   reg [CNT_W-1:0] wr_cnt_reg;
   reg [31:0] last_addr_reg;

   // access engine
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg load_reg;

   wire region1;
   wire [31:0] acc_addr;
   wire rd_ok;
   wire wr_ok;
   wire idle;
   wire take_rd;
   wire take_wr;
   wire rd_pass;
   wire wr_pass;
   wire rd_stop;
   wire wr_stop;
   wire clr_rd_blk;
   wire clr_wr_blk;
   reg [31:0] status_word;
   wire [31:0] dport;

   // helpers shared by the decode, the counters and the readback
   function reg_hit;
      input [`HMW_ADDR_W-1:0] addr;
      input [`HMW_ADDR_W-1:0] offs;
      begin
         reg_hit = (addr == offs);
      end
   endfunction

   // refusal counters stop at all ones instead of wrapping
   function [CNT_W-1:0] sat_inc;
      input [CNT_W-1:0] cnt;
      begin
         if (cnt == {CNT_W{1'b1}}) begin
            sat_inc = cnt;
         end else begin
            sat_inc = cnt + 1'b1;
         end
      end
   endfunction

   function [31:0] ceil_word;
      input [12:0] ceil;
      begin
         ceil_word = {17'h00000, ceil, 2'h0};
      end
   endfunction

   hmw_region_check u_check (
      .window_offset_i(window_offset_i),
      .r0_base_i(r0_base_reg),
      .r0_rd_ceil_i(r0_rd_ceil_reg),
      .r0_wr_ceil_i(r0_wr_ceil_reg),
      .r1_base_i(r1_base_i),
      .r1_rd_ceil_i(r1_rd_ceil_i),
      .r1_wr_ceil_i(r1_wr_ceil_i),
      .region1_o(region1),
      .addr_o(acc_addr),
      .rd_ok_o(rd_ok),
      .wr_ok_o(wr_ok)
   );

   // data port takes the fetched word, or the bytes the host wrote
   hmw_data_port u_dport (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(load_reg),
      .load_data_i(mem_rdata_i),
      .wr_i(take_wr),
      .be_i(window_be_i),
      .wdata_i(window_wdata_i),
      .data_o(dport)
   );

   assign window_data_port_o = dport;

   // one access at a time; a read wins over a write in the same cycle
   assign idle = (state_reg == ST_IDLE);
   assign take_rd = idle && window_rd_i;
   assign take_wr = idle && window_wr_i && !window_rd_i;
   assign rd_pass = take_rd && ctrl_en_reg && rd_ok;
   assign wr_pass = take_wr && ctrl_en_reg && wr_ok && (window_be_i != 4'h0);
   assign rd_stop = take_rd && !rd_pass;
   assign wr_stop = take_wr && !(ctrl_en_reg && wr_ok);

   assign clr_rd_blk = reg_wr_i && reg_hit(reg_addr_i, `HMW_OFF_STATUS)
                       && reg_wdata_i[`HMW_ST_RD_BLK_BIT];
   assign clr_wr_blk = reg_wr_i && reg_hit(reg_addr_i, `HMW_OFF_STATUS)
                       && reg_wdata_i[`HMW_ST_WR_BLK_BIT];

   // counters sit at fixed fields; unused upper bits read zero
   always @* begin
      status_word = 32'h00000000;
      status_word[`HMW_ST_RD_BLK_BIT] = rd_blk_reg;
      status_word[`HMW_ST_WR_BLK_BIT] = wr_blk_reg;
      status_word[`HMW_ST_BUSY_BIT] = !idle;
      status_word[`HMW_ST_REGION_BIT] = region_reg;
      status_word[`HMW_ST_RD_CNT_LO +: CNT_W] = rd_cnt_reg;
      status_word[`HMW_ST_WR_CNT_LO +: CNT_W] = wr_cnt_reg;
   end

   // register writes
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         r0_base_reg <= `HMW_RST_BASE;
         r0_rd_ceil_reg <= `HMW_RST_CEIL;
         r0_wr_ceil_reg <= `HMW_RST_CEIL;
         ctrl_en_reg <= `HMW_RST_CTRL;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `HMW_OFF_R0_BASE: begin
               r0_base_reg <= reg_wdata_i[31:2];
            end
            `HMW_OFF_R0_RD_CEIL: begin
               r0_rd_ceil_reg <= reg_wdata_i[`HMW_CEIL_HI:`HMW_CEIL_LO];
            end
            `HMW_OFF_R0_WR_CEIL: begin
               r0_wr_ceil_reg <= reg_wdata_i[`HMW_CEIL_HI:`HMW_CEIL_LO];
            end
            `HMW_OFF_CTRL: begin
               ctrl_en_reg <= reg_wdata_i[`HMW_CTRL_EN_BIT];
            end
            default: begin
               ctrl_en_reg <= ctrl_en_reg;
            end
         endcase
      end
   end

   // sticky refusal flags, counters and last target; a new refusal beats a clear
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         rd_blk_reg <= 1'b0;
         wr_blk_reg <= 1'b0;
         rd_cnt_reg <= {CNT_W{1'b0}};
         wr_cnt_reg <= {CNT_W{1'b0}};
         region_reg <= 1'b0;
         last_addr_reg <= 32'h00000000;
      end else begin
         if (rd_stop) begin
            rd_blk_reg <= 1'b1;
         end else if (clr_rd_blk) begin
            rd_blk_reg <= 1'b0;
         end
         if (wr_stop) begin
            wr_blk_reg <= 1'b1;
         end else if (clr_wr_blk) begin
            wr_blk_reg <= 1'b0;
         end
         if (rd_stop) begin
            rd_cnt_reg <= sat_inc(rd_cnt_reg);
         end
         if (wr_stop) begin
            wr_cnt_reg <= sat_inc(wr_cnt_reg);
         end
         if (take_rd || take_wr) begin
            region_reg <= region1;
            last_addr_reg <= acc_addr;
         end
      end
   end

   // register read data, one cycle after the strobe; reserved bits read zero
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `HMW_OFF_R0_BASE: begin
               reg_rdata_o <= {r0_base_reg, 2'h0};
            end
            `HMW_OFF_R0_RD_CEIL: begin
               reg_rdata_o <= ceil_word(r0_rd_ceil_reg);
            end
            `HMW_OFF_R0_WR_CEIL: begin
               reg_rdata_o <= ceil_word(r0_wr_ceil_reg);
            end
            `HMW_OFF_CTRL: begin
               reg_rdata_o <= {31'h00000000, ctrl_en_reg};
            end
            `HMW_OFF_STATUS: begin
               reg_rdata_o <= status_word;
            end
            `HMW_OFF_LAST_ADDR: begin
               reg_rdata_o <= last_addr_reg;
            end
            `HMW_OFF_DATA_PORT: begin
               reg_rdata_o <= dport;
            end
            default: begin
               reg_rdata_o <= 32'h00000000;
            end
         endcase
      end else begin
         reg_rdata_o <= 32'h00000000;
      end
   end

   // read sequence: strobe, memory answers next cycle, data port loads
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (rd_pass) begin
               state_next = ST_RWAIT;
            end
         end
         ST_RWAIT: begin
            state_next = ST_RLOAD;
         end
         ST_RLOAD: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         state_reg <= ST_IDLE;
         load_reg <= 1'b0;
         mem_addr_o <= 32'h00000000;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         mem_be_o <= 4'h0;
         mem_wdata_o <= 32'h00000000;
         window_done_o <= 1'b0;
         window_blocked_o <= 1'b0;
         window_busy_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         load_reg <= (state_reg == ST_RWAIT);
         mem_rd_o <= rd_pass;
         mem_wr_o <= wr_pass;
         window_busy_o <= (state_next != ST_IDLE);
         if (rd_pass || wr_pass) begin
            mem_addr_o <= acc_addr;
         end
         if (wr_pass) begin
            mem_be_o <= window_be_i;
            mem_wdata_o <= window_wdata_i;
         end else begin
            mem_be_o <= 4'h0;
         end
         window_done_o <= rd_stop || take_wr || (state_reg == ST_RLOAD);
         window_blocked_o <= rd_stop || wr_stop;
      end
   end

endmodule // hmw_window
`default_nettype wire

// File: verification/hmw_window_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hmw_window_chk (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [15:0] window_offset_i,
   input wire logic window_rd_i,
   input wire logic window_wr_i,
   input wire logic [3:0] window_be_i,
   input wire logic [31:0] window_data_port_o,
   input wire logic window_done_o,
   input wire logic window_blocked_o,
   input wire logic window_busy_o,
   input wire logic [31:0] r1_base_i,
   input wire logic [15:0] r1_rd_ceil_i,
   input wire logic [15:0] r1_wr_ceil_i,
   input wire logic [31:0] mem_addr_o,
   input wire logic mem_rd_o,
   input wire logic mem_wr_o,
   input wire logic [3:0] mem_be_o,
   input wire logic [31:0] mem_rdata_i
);
   logic [29:0] base_reg;
   logic [12:0] rc_reg;
   logic [12:0] wc_reg;
   logic en_reg;
   logic r1, rd_tk, wr_tk, rd_ok, wr_ok;
   logic [12:0] wo;
   logic [31:0] tgt;
   assign wo = window_offset_i[14:2];
   assign r1 = window_offset_i[15];
   assign rd_tk = window_rd_i && !window_busy_o;
   assign wr_tk = window_wr_i && !window_rd_i && !window_busy_o;
   assign rd_ok = en_reg && (r1 ? wo < r1_rd_ceil_i[14:2] : wo < rc_reg);
   assign wr_ok = en_reg && (r1 ? wo < r1_wr_ceil_i[14:2] : wo < wc_reg);
   assign tgt = (r1 ? {r1_base_i[31:2], 2'h0} : {base_reg, 2'h0}) + {17'h0, wo, 2'h0};
   // shadow of the software-visible settings
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         base_reg <= 30'h0;
         rc_reg <= 13'h0;
         wc_reg <= 13'h0;
         en_reg <= 1'h1;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            12'h104: base_reg <= reg_wdata_i[31:2];
            12'h108: rc_reg <= reg_wdata_i[14:2];
            12'h10A: wc_reg <= reg_wdata_i[14:2];
            12'h114: en_reg <= reg_wdata_i[0];
            default: ;
         endcase
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence rd_wait;
      window_busy_o [*2];
   endsequence
   sequence rd_end;
      window_done_o && !window_blocked_o && window_data_port_o == $past(mem_rdata_i);
   endsequence
   AST_RD_FETCH: assert property (rd_tk && rd_ok |=>
      mem_rd_o && mem_addr_o == $past(tgt))
      else $error("read fetch wrong");
   AST_RD_DONE: assert property (rd_tk && rd_ok |=> rd_wait ##1 rd_end)
      else $error("read completion wrong");
   AST_RD_BLOCK: assert property (rd_tk && !rd_ok |=>
      !mem_rd_o && window_done_o && window_blocked_o)
      else $error("read not refused");
   AST_WR_STORE: assert property (wr_tk && wr_ok && window_be_i != 4'h0 |=>
      mem_wr_o && mem_be_o == $past(window_be_i) && mem_addr_o == $past(tgt))
      else $error("write store wrong");
   AST_WR_BLOCK: assert property (wr_tk && !wr_ok |=>
      !mem_wr_o && window_done_o && window_blocked_o)
      else $error("write not refused");
   AST_NO_SPUR_WR: assert property (mem_wr_o |->
      $past(wr_tk && wr_ok && window_be_i != 4'h0))
      else $error("unexpected memory write");
   AST_BASE_RD: assert property (reg_rd_i && reg_addr_i == 12'h104 |=>
      reg_rdata_o == {base_reg, 2'h0})
      else $error("base readback wrong");
   AST_RC_RD: assert property (reg_rd_i && reg_addr_i == 12'h108 |=>
      reg_rdata_o == {17'h0, rc_reg, 2'h0})
      else $error("read ceiling readback wrong");
   AST_WC_RD: assert property (reg_rd_i && reg_addr_i == 12'h10A |=>
      reg_rdata_o == {17'h0, wc_reg, 2'h0})
      else $error("write ceiling readback wrong");
endmodule // hmw_window_chk
bind hmw_window hmw_window_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .window_offset_i(window_offset_i), .window_rd_i(window_rd_i), .window_wr_i(window_wr_i),
   .window_be_i(window_be_i), .window_data_port_o(window_data_port_o),
   .window_done_o(window_done_o), .window_blocked_o(window_blocked_o),
   .window_busy_o(window_busy_o), .r1_base_i(r1_base_i), .r1_rd_ceil_i(r1_rd_ceil_i),
   .r1_wr_ceil_i(r1_wr_ceil_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
   .mem_wr_o(mem_wr_o), .mem_be_o(mem_be_o), .mem_rdata_i(mem_rdata_i));
`default_nettype wire

// File: verification/hmw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module hmw_mem_model (
   input wire logic clk_i,
   input wire logic [31:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [3:0] be_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [0:1023];
   initial begin
      rdata_o = 32'h0;
      for (int i = 0; i < 1024; i++) mem[i] = 32'hA5000000 | i;
   end
   // data stand only in the cycle after the read; otherwise the bus toggles
   always @(posedge clk_i) begin
      rdata_o <= rd_i ? mem[addr_i[11:2]] : ~rdata_o;
      if (wr_i) begin
         for (int b = 0; b < 4; b++) if (be_i[b]) mem[addr_i[11:2]][8*b+:8] <= wdata_i[8*b+:8];
      end
   end
endmodule // hmw_mem_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i, nrst_i, reg_wr_i, reg_rd_i, window_rd_i, window_wr_i, blk;
   logic [11:0] reg_addr_i;
   logic [15:0] window_offset_i, r1_rd_ceil_i, r1_wr_ceil_i;
   logic [3:0] window_be_i;
   logic [31:0] reg_wdata_i, window_wdata_i, r1_base_i, v, dp, ma;
   logic [31:0] reg_rdata_o, window_data_port_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
   logic window_done_o, window_blocked_o, window_busy_o, mem_rd_o, mem_wr_o;
   logic [3:0] mem_be_o;
   int mismatches, tests_run, wr_cnt, n0;
   hmw_window dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .window_offset_i(window_offset_i), .window_rd_i(window_rd_i),
      .window_wr_i(window_wr_i), .window_be_i(window_be_i), .window_wdata_i(window_wdata_i),
      .window_data_port_o(window_data_port_o), .window_done_o(window_done_o),
      .window_blocked_o(window_blocked_o), .window_busy_o(window_busy_o),
      .r1_base_i(r1_base_i), .r1_rd_ceil_i(r1_rd_ceil_i), .r1_wr_ceil_i(r1_wr_ceil_i),
      .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_be_o(mem_be_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
   hmw_mem_model u_mem (.clk_i(clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
      .be_i(mem_be_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (mem_wr_o === 1'b1) wr_cnt <= wr_cnt + 1;
   function logic [31:0] pat(input logic [31:0] i);
      return 32'hA5000000 | i;
   endfunction
   task final_report;
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task rw(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task rr(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("register", e, reg_rdata_o);
   endtask
   task wa(input logic rd, input logic [15:0] o, input logic [3:0] be, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      window_rd_i <= rd;
      window_wr_i <= !rd;
      window_offset_i <= o;
      window_be_i <= be;
      window_wdata_i <= d;
      @(posedge clk_i);
      window_rd_i <= 1'b0;
      window_wr_i <= 1'b0;
      #1 n = 0;
      while (window_done_o !== 1'b1 && n < 8) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("done", 32'h1, {31'h0, window_done_o});
      blk = window_blocked_o;
      dp = window_data_port_o;
      ma = mem_addr_o;
   endtask
   task rx(input logic [15:0] o, input logic eb, input logic [31:0] ea, input logic [31:0] ed);
      wa(1'b1, o, 4'h0, 32'h0);
      chk("blocked", {31'h0, eb}, {31'h0, blk});
      chk("data port", ed, dp);
      if (!eb) chk("mem addr", ea, ma);
   endtask
   initial begin
      nrst_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 12'h0;
      reg_wdata_i = 32'h0;
      window_rd_i = 1'b0;
      window_wr_i = 1'b0;
      window_offset_i = 16'h0;
      window_be_i = 4'h0;
      window_wdata_i = 32'h0;
      r1_base_i = 32'h00000203;
      r1_rd_ceil_i = 16'h0100;
      r1_wr_ceil_i = 16'h0100;
      mismatches = 0;
      tests_run = 0;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      rr(12'h104, 32'h0);
      rr(12'h108, 32'h0);
      rr(12'h10A, 32'h0);
      rr(12'h200, 32'h0);
      rx(16'h0000, 1'b1, 32'h0, 32'h0);
      rw(12'h104, 32'h00000107);
      rr(12'h104, 32'h00000104);
      rw(12'h108, 32'h00008043);
      rr(12'h108, 32'h00000040);
      rw(12'h10A, 32'h00008023);
      rr(12'h10A, 32'h00000020);
      rx(16'h000C, 1'b0, 32'h110, pat(32'h44));
      rx(16'h003C, 1'b0, 32'h140, pat(32'h50));
      rx(16'h0040, 1'b1, 32'h0, pat(32'h50));
      n0 = wr_cnt;
      wa(1'b0, 16'h001C, 4'h5, 32'h11223344);
      chk("write blocked", 32'h0, {31'h0, blk});
      @(posedge clk_i);
      #1 chk("write count", n0 + 1, wr_cnt);
      rx(16'h001C, 1'b0, 32'h120, 32'hA5220044);
      wa(1'b0, 16'h0020, 4'hF, 32'hDEADBEEF);
      chk("write blocked", 32'h1, {31'h0, blk});
      @(posedge clk_i);
      #1 chk("write count", n0 + 1, wr_cnt);
      rx(16'h0020, 1'b0, 32'h124, pat(32'h49));
      rx(16'h8050, 1'b0, 32'h250, pat(32'h94));
      rr(12'h118, 32'h0001020B);
      rr(12'h11C, 32'h00000250);
      rr(12'h120, pat(32'h94));
      rr(12'h114, 32'h00000001);
      rw(12'h118, 32'h00000003);
      rr(12'h118, 32'h00010208);
      rw(12'h114, 32'h00000000);
      rx(16'h000C, 1'b1, 32'h0, pat(32'h94));
      rr(12'h118, 32'h00010301);
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      rr(12'h104, 32'h0);
      rr(12'h108, 32'h0);
      rr(12'h114, 32'h00000001);
      rr(12'h118, 32'h00000000);
      final_report;
   end
   initial begin
      #100000;
      mismatches++;
      final_report;
   end
endmodule // tb_top
`default_nettype wire
